// ### logic/cram_array.sv
/*
 array of ram blocks joined in width and depth into one store.
 assumes user logic drives req and data synchronous to clk (global).
*/
// Contract
// - block makes its own write strobe from the clock edge.
// - block shapes 256x16, 512x8, 1024x4 or 2048x2.
// - same-depth blocks side by side share address, widen the word.
// - depth chaining up to 2048 words adds no access delay.
// - blocks can join one combined memory, addressable only up to 2048 words deep.
`timescale 1ns/1ns
module cram_array #(
   parameter int WIDE = 2,
   parameter int DEEP = 1,
   parameter int ADDR_W = 9
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire cram_pkg::cram_shape_t shape,
   input wire cram_pkg::cram_req_t req,
   input wire logic [WIDE*cram_pkg::MAX_DATA_W-1:0] wrData,
   output logic [WIDE*cram_pkg::MAX_DATA_W-1:0] rdData,
   output logic wrDone
);
   localparam int DW = cram_pkg::MAX_DATA_W;
   localparam int SELW = (DEEP > 1) ? $clog2(DEEP) : 1;
   initial begin
      if (WIDE < 1 || DEEP < 1 || ADDR_W > cram_pkg::MAX_ADDR_W + SELW
         || ADDR_W < cram_pkg::MIN_ADDR_W) begin
         $error("cram_array: parameters out of range");
      end
   end
   // ***************************************
   // address split per shape
   // ***************************************
   wire logic [1:0] shapeCode = shape;
   wire logic [3:0] blkAddrW = 4'(cram_pkg::MIN_ADDR_W)
      + {2'b00, shapeCode};
   wire logic [cram_pkg::MAX_ADDR_W-1:0] blkMask =
      11'((12'h001 << blkAddrW) - 12'h001);
   wire logic [cram_pkg::MAX_ADDR_W-1:0] blkAddr = req.addr & blkMask;
   // depth chaining capped at the largest block depth
   wire logic [SELW-1:0] blkSel = SELW'(req.addr >> blkAddrW);
   logic [SELW-1:0] rdSel;
   logic [WIDE*DW-1:0] blkOut [DEEP];
   // ***************************************
   // block grid
   // ***************************************
   genvar d, w;
   generate
      for (d = 0; d < DEEP; d++) begin : g_deep
         for (w = 0; w < WIDE; w++) begin : g_wide
            cram_block u_blk (
               .clk(clk),
               .shape(shape),
               .wrReq(req.wrReq && blkSel == SELW'(d)),
               .addr(blkAddr),
               .wrData(wrData[w*DW +: DW]),
               .rdData(blkOut[d][w*DW +: DW])
            );
         end
      end
   endgenerate
   // read mux after the block registers keeps one cycle latency
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdSel <= '0;
         wrDone <= 1'b0;
      end else begin
         rdSel <= blkSel;
         wrDone <= req.wrReq;
      end
   end
   assign rdData = blkOut[rdSel];
   // ***************************************
   // checks
   // ***************************************
   logic [cram_pkg::MAX_ADDR_W-1:0] lastAddr;
   logic lastWr;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lastAddr <= '0;
         lastWr <= 1'b0;
      end else begin
         lastAddr <= req.addr;
         lastWr <= req.wrReq;
      end
   end
   AST_WRDONE: assert property (@(posedge clk) disable iff (!arst_n)
      req.wrReq |=> wrDone)
      else $error("write not acknowledged next cycle");
   AST_NOWR: assert property (@(posedge clk) disable iff (!arst_n)
      !req.wrReq |=> !wrDone)
      else $error("spurious write acknowledge");
   AST_WRTHRU: assert property (@(posedge clk) disable iff (!arst_n)
      (req.wrReq && shape == cram_pkg::CRAM_SHAPE_256X16) ##1
      ($stable(req.addr) && !req.wrReq && $stable(shape))
      |=> rdData[DW-1:0] == $past(wrData[DW-1:0], 2))
      else $error("written word not read back");
   AST_LAT: assert property (@(posedge clk) disable iff (!arst_n)
      ##1 rdSel == $past(blkSel))
      else $error("chained read latency differs");
   AST_WIDE: assert property (@(posedge clk) disable iff (!arst_n)
      (req.wrReq && shape == cram_pkg::CRAM_SHAPE_512X8) ##1
      ($stable(req.addr) && !req.wrReq && $stable(shape))
      |=> rdData[DW+7:DW] == $past(wrData[DW+7:DW], 2))
      else $error("wide half lost");
   AST_NARROW: assert property (@(posedge clk) disable iff (!arst_n)
      ##1 $past(shape) == cram_pkg::CRAM_SHAPE_2KX2
      |-> rdData[DW-1:2] == '0)
      else $error("2-bit shape leaks upper bits");
   AST_SEL: assert property (@(posedge clk) disable iff (!arst_n)
      rdSel < SELW'(DEEP) || DEEP == (1 << SELW))
      else $error("select outside chained blocks");
   // a second write to one address still returns the first word
   AST_RBW: assert property (@(posedge clk) disable iff (!arst_n)
      (req.wrReq && lastWr && req.addr == lastAddr
      && shape == cram_pkg::CRAM_SHAPE_256X16 && $stable(shape))
      |=> rdData[DW-1:0] == $past(wrData[DW-1:0], 2))
      else $error("write cycle did not return old word");
   // unused bits of every slice stay zero in the 512x8 and 1024x4 shapes
   genvar z;
   generate
      for (z = 0; z < WIDE; z++) begin : g_fill
         AST_FILL8: assert property (@(posedge clk) disable iff (!arst_n)
            ##1 $past(shape) == cram_pkg::CRAM_SHAPE_512X8
            |-> rdData[z*DW+DW/2 +: DW/2] == '0)
            else $error("8-bit shape leaks upper bits");
         AST_FILL4: assert property (@(posedge clk) disable iff (!arst_n)
            ##1 $past(shape) == cram_pkg::CRAM_SHAPE_1KX4
            |-> rdData[z*DW+DW/4 +: DW*3/4] == '0)
            else $error("4-bit shape leaks upper bits");
      end
   endgenerate
   COV_WR: cover property (@(posedge clk) req.wrReq ##1 !req.wrReq);
   COV_B2B: cover property (@(posedge clk) req.wrReq ##1 req.wrReq);
   COV_2K: cover property (@(posedge clk)
      shape == cram_pkg::CRAM_SHAPE_2KX2 && req.wrReq);
   COV_RBW: cover property (@(posedge clk)
      req.wrReq && lastWr && req.addr == lastAddr);
   COV_1K: cover property (@(posedge clk)
      shape == cram_pkg::CRAM_SHAPE_1KX4 && req.wrReq);
endmodule

// ### logic/cram_block.sv
/*
 one ram block of 4096 bits, reshapable by shape code.
 assumes address, data and write request are synchronous to clk.
*/
`timescale 1ns/1ns
module cram_block #(
   parameter int BITS = cram_pkg::BLOCK_BITS
) (
   input wire logic clk,
   input wire cram_pkg::cram_shape_t shape,
   input wire logic wrReq,
   input wire logic [cram_pkg::MAX_ADDR_W-1:0] addr,
   input wire logic [cram_pkg::MAX_DATA_W-1:0] wrData,
   output logic [cram_pkg::MAX_DATA_W-1:0] rdData
);
   // ***************************************
   // storage and shape decode
   // ***************************************
   logic [BITS-1:0] mem;
   // shape decode below only spans the one block size
   initial begin
      if (BITS != cram_pkg::BLOCK_BITS) begin
         $error("cram_block: block size not supported");
      end
   end
   wire logic [1:0] shapeCode = shape;
   wire logic [4:0] dataWidth = 5'(cram_pkg::MAX_DATA_W) >> shapeCode;
   wire logic [11:0] bitBase = 12'(addr) << (3'(cram_pkg::WIDTH_SHIFT_BASE)
      - {1'b0, shapeCode});
   // write strobe made here from the clock edge, no user pulse needed
   always_ff @(posedge clk) begin
      if (wrReq) begin
         for (int b = 0; b < cram_pkg::MAX_DATA_W; b++) begin
            if (5'(b) < dataWidth) begin
               mem[12'(bitBase + 12'(b))] <= wrData[b];
            end
         end
      end
   end
   // read-through word, narrow shapes zero filled above
   always_ff @(posedge clk) begin
      for (int b = 0; b < cram_pkg::MAX_DATA_W; b++) begin
         rdData[b] <= (5'(b) < dataWidth) ?
            mem[12'(bitBase + 12'(b))] : 1'b0;
      end
   end
endmodule

// ### pkg/cram_pkg.sv
/*
 configurable ram array package: shape codes, widths and depth limits.
 assumes a single synchronous clock domain around the array.
*/
package cram_pkg;
   // ***************************************
   // shapes of one ram block
   // ***************************************
   typedef enum logic [1:0] {
      CRAM_SHAPE_256X16 = 2'h0,
      CRAM_SHAPE_512X8 = 2'h1,
      CRAM_SHAPE_1KX4 = 2'h2,
      CRAM_SHAPE_2KX2 = 2'h3
   } cram_shape_t;
   localparam int BLOCK_BITS = 4096;
   localparam int MAX_DATA_W = 16;
   localparam int MAX_ADDR_W = 11;
   localparam int MIN_ADDR_W = 8;
   localparam int MAX_DEPTH = 2048;
   localparam int WIDTH_SHIFT_BASE = 4;
   // ***************************************
   // user side request bundle
   // ***************************************
   typedef struct packed {
      logic wrReq;
      logic [MAX_ADDR_W-1:0] addr;
   } cram_req_t;
endpackage

// ### verification/cram_user.sv
/*
 user logic model: drives request and write word on the global clock.
 assumes the bench calls put and idle from a single process.
*/
`timescale 1ns/1ns
module cram_user (
   input wire logic clk,
   output cram_pkg::cram_req_t req,
   output logic [31:0] wrData
);
   initial begin
      req = '0;
      wrData = 32'h0;
   end
   // held a full cycle, so the taking edge sees a settled request
   task automatic put(input logic wr, input logic [10:0] a,
      input logic [31:0] d);
      @(posedge clk);
      #1;
      req.wrReq = wr;
      req.addr = a;
      wrData = d;
   endtask
   // idle lines keep moving so stale values never look valid;
   // only the low address bits flip, so the chain select stays put
   task automatic idle();
      @(posedge clk);
      #1;
      req.wrReq = 1'b0;
      req.addr = req.addr ^ 11'h0FF;
      wrData = ~wrData;
   endtask
endmodule

// ### verification/tb_cram_array.sv
/*
 bench for cram_array: every shape, double-wide words, write ordering.
 assumes cram_user stands in for the user logic on the request side.
*/
`timescale 1ns/1ns
module tb_cram_array;
   typedef struct {int c; logic wr; logic chk; logic [31:0] d;} cram_note_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   cram_pkg::cram_shape_t shape = cram_pkg::CRAM_SHAPE_256X16;
   cram_pkg::cram_req_t req;
   logic [31:0] wrData, rdData;
   logic wrDone;
   logic [31:0] mem [int];
   cram_note_t q[$];
   int cyc = 0, num_errors = 0, checks = 0;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         num_errors++;
         finish_test();
      end
   end
   cram_array u_dut (.clk(clk), .arst_n(arst_n), .shape(shape), .req(req),
      .wrData(wrData), .rdData(rdData), .wrDone(wrDone));
   cram_user u_user (.clk(clk), .req(req), .wrData(wrData));
   // narrow shapes zero fill the unused bits of each slice
   function automatic logic [31:0] fit(input logic [31:0] d);
      logic [15:0] m;
      m = 16'hFFFF >> (16 - (16 >> shape));
      return {d[31:16] & m, d[15:0] & m};
   endfunction
   task automatic check(input logic ok, input string msg);
      checks++;
      if (!ok) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic op(input logic wr, input logic [10:0] a,
      input logic [31:0] d);
      cram_note_t n;
      u_user.put(wr, a, d);
      n.c = cyc + 1;
      n.wr = wr;
      n.chk = mem.exists(a);
      n.d = mem.exists(a) ? mem[a] : 32'h0;
      if (wr) mem[a] = fit(d);
      q.push_back(n);
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ************
   // scoreboard
   // ************
   initial forever begin
      @(posedge clk);
      #5;
      while (q.size() > 0 && q[0].c == cyc) begin
         check(wrDone === q[0].wr, "done flag");
         if (q[0].chk) check(rdData === q[0].d, "read word");
         void'(q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'h2EBE));
      repeat (6) @(posedge clk);
      check(wrDone === 1'b0, "done in reset");
      #1 arst_n = 1'b1;
      for (int s = 0; s < 4; s++) begin
         shape = cram_pkg::cram_shape_t'(s);
         mem.delete();
         for (int i = 0; i < 8; i++)
            op(1'b1, 11'($urandom % (256 << s)), $urandom);
         foreach (mem[a]) op(1'b0, 11'(a), 32'h0);
         op(1'b1, 11'h0, 32'hA5A5_5A5A);
         op(1'b1, 11'h0, 32'h1234_5678);
         op(1'b0, 11'h0, 32'h0);
         repeat (2) u_user.idle();
         $display("shape %0d test done", s);
      end
      finish_test();
   end
endmodule
